// [src/tpp_pkg.sv]
// Constants shared by the timer channel: mode and pin action codes, reset values.
// Assumes a single 200 MHz timer clock; registers are plain ports, no bus.
`default_nettype none
package tpp_pkg;
   // ---------------------------------------------------------------
   // Field codes
   // ---------------------------------------------------------------
   localparam logic [1:0] MODE_COMPARE = 2'h0;
   localparam logic [1:0] MODE_CAPTURE = 2'h1;
   localparam logic [1:0] MODE_PULSE   = 2'h2;
   localparam logic [1:0] MODE_TIMER   = 2'h3;
   localparam logic [1:0] PIN_LOW      = 2'h0;
   localparam logic [1:0] PIN_HIGH     = 2'h1;
   localparam logic [1:0] PIN_PWM      = 2'h2;
   localparam logic [1:0] PIN_SINGLE   = 2'h3;
   localparam logic [1:0] CAP_RISE     = 2'h0;
   localparam logic [1:0] CAP_FALL     = 2'h1;
   localparam logic [1:0] CAP_BOTH     = 2'h2;
   localparam logic [1:0] CAP_NONE     = 2'h3;
   // ---------------------------------------------------------------
   // Widths and reset values
   // ---------------------------------------------------------------
   localparam int          CNT_W        = 16;
   localparam int          P_LSB        = 8;
   localparam logic [15:0] CNT_RESET    = 16'h0000;
   localparam logic [15:0] COMP_A_RESET = 16'h0000;
   localparam logic [7:0]  P_ZERO       = 8'h00;
   localparam logic [16:0] FULL_SPAN    = 17'h10000;
endpackage : tpp_pkg
`default_nettype wire

// [src/tpp_edge_sync.sv]
// Two-stage synchroniser with one-cycle edge pulses.
// Assumes the input is asynchronous to clk.
`default_nettype none
module tpp_edge_sync
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic async_in,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic meta;
   logic sync;
   logic prev;

   // First stage feeds only the second
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end
      else
      begin
         meta <= async_in;
         sync <= meta;
         prev <= sync;
      end
   end

   assign level = sync;
   assign rise  = sync & ~prev;
   assign fall  = ~sync & prev;
endmodule : tpp_edge_sync
`default_nettype wire

// [src/tpp_timer.sv]
// Timer channel: PWM output, single pulse output and capture input modes.
// Assumes software holds the control bits steady between uses; pins are async.
//
// Contract
// - Swap set: period compare A, duty P*256
// - Counter clear defines PWM period
// - PWM counting continues with pin forced
// - PWM ignores clear source select
// - Trigger pin edge sets run bit
// - Run rise starts counter, leading edge
// - Compare A match ends pulse, clears run
// - Compare A flag on pulse end
// - Counter stops at match, zeroed on restart
// - Single pulse ignores P, clear, swap
// - Mode 01 is capture, edges selectable
// - Capture counter free runs while run
// - Capture edge copies counter, raises flag
// - Capture P match zeroes counter, flags
// - Capture P zero runs full count
// - Pin action 11 disables capture only
// - Capture drives no output function
// - Duty at or above period gives 100%
// - Initial level polarity, invert reverses
`default_nettype none
module tpp_timer
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        mode_select_hi,
   input  wire logic        mode_select_lo,
   input  wire logic [1:0]  pin_action_select,
   input  wire logic        output_initial_level,
   input  wire logic        output_invert,
   input  wire logic        clear_source_select,
   input  wire logic        duty_period_swap_select,
   input  wire logic        run_set,
   input  wire logic        run_clear,
   input  wire logic        compare_a_write,
   input  wire logic [15:0] compare_a_wdata,
   input  wire logic [7:0]  compare_p_value,
   input  wire logic        external_trigger_pin,
   input  wire logic        capture_input_pin,
   output logic             counter_run_bit,
   output logic [15:0]      compare_a_value,
   output logic [15:0]      count,
   output logic             timer_output,
   output logic             flag_a_pulse,
   output logic             flag_p_pulse
);
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic trig_rise;
   logic cap_level;
   logic cap_rise;
   logic cap_fall;

   tpp_edge_sync u_trig
   (
      .clk      (clk),
      .rst      (rst),
      .async_in (external_trigger_pin),
      .level    (),
      .rise     (trig_rise),
      .fall     ()
   );

   tpp_edge_sync u_cap
   (
      .clk      (clk),
      .rst      (rst),
      .async_in (capture_input_pin),
      .level    (cap_level),
      .rise     (cap_rise),
      .fall     (cap_fall)
   );

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   wire [1:0] mode      = {mode_select_hi, mode_select_lo};
   wire       is_capt   = (mode == tpp_pkg::MODE_CAPTURE);
   wire       is_pwm    = (mode == tpp_pkg::MODE_PULSE) && (pin_action_select != tpp_pkg::PIN_SINGLE);
   wire       is_single = (mode == tpp_pkg::MODE_PULSE) && (pin_action_select == tpp_pkg::PIN_SINGLE);

   logic run_prev;
   wire  run_rise = counter_run_bit & ~run_prev;

   wire match_a = (count == compare_a_value);
   // P compares the high byte; zero means the full 65536 span
   wire match_p = (compare_p_value == tpp_pkg::P_ZERO)
                  ? (count == 16'hffff)
                  : (count == {compare_p_value, 8'h00});

   // PWM period/duty choice; clear_source_select is not looked at
   wire [16:0] p_span = (compare_p_value == tpp_pkg::P_ZERO)
                        ? tpp_pkg::FULL_SPAN : {1'b0, compare_p_value, 8'h00};
   wire [16:0] a_span = {1'b0, compare_a_value};
   wire [16:0] period = duty_period_swap_select ? a_span : p_span;
   wire [16:0] duty   = duty_period_swap_select ? p_span : a_span;
   // Clear on the last count so the period is exactly the span, not one more
   wire pwm_clear = ({1'b0, count} == (period - 17'h00001));
   wire        duty_full = (duty >= period);
   wire        pwm_act   = duty_full || ({1'b0, count} < duty);
   wire        pwm_wave  = (pwm_act ? output_initial_level : ~output_initial_level)
                           ^ output_invert;

   // Capture edge choice; code 11 never captures
   wire cap_edge = is_capt && counter_run_bit &&
                   ((pin_action_select == tpp_pkg::CAP_RISE && cap_rise) ||
                    (pin_action_select == tpp_pkg::CAP_FALL && cap_fall) ||
                    (pin_action_select == tpp_pkg::CAP_BOTH && (cap_rise || cap_fall)));

   wire single_end = is_single && counter_run_bit && !run_rise && match_a;

   // Run bit: hardware set beats the clear in the same cycle
   wire next_run = (run_set || (is_single && trig_rise)) ? 1'b1
                 : (run_clear || single_end) ? 1'b0
                 : counter_run_bit;

   logic [15:0] next_count;
   always_comb
   begin
      next_count = count;
      if (run_rise)
         next_count = tpp_pkg::CNT_RESET;
      else if (counter_run_bit)
      begin
         if (is_pwm && pwm_clear)
            next_count = tpp_pkg::CNT_RESET;
         else if (is_capt && match_p)
            next_count = tpp_pkg::CNT_RESET;
         else if (single_end)
            next_count = count;
         else
            next_count = count + 16'h0001;
      end
   end

   // Pin: pulse is the run bit XOR output_invert; capture leaves pin at rest
   wire next_out = is_pwm ? ((pin_action_select == tpp_pkg::PIN_PWM) ? pwm_wave
                              : (pin_action_select == tpp_pkg::PIN_HIGH))
                 : is_single ? (next_run ^ output_invert)
                 : 1'b0;

   // In PWM the period comparator flags at the clear, the duty one at its match
   wire pwm_hit_a   = duty_period_swap_select ? pwm_clear : match_a;
   wire pwm_hit_p   = duty_period_swap_select ? match_p : pwm_clear;
   wire next_flag_a = (is_pwm && counter_run_bit && pwm_hit_a) || single_end || cap_edge;
   wire next_flag_p = (is_pwm && counter_run_bit && !run_rise && pwm_hit_p)
                    || (is_capt && counter_run_bit && !run_rise && match_p);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         counter_run_bit <= 1'b0;
         run_prev        <= 1'b0;
         count           <= tpp_pkg::CNT_RESET;
         compare_a_value <= tpp_pkg::COMP_A_RESET;
         timer_output    <= 1'b0;
         flag_a_pulse    <= 1'b0;
         flag_p_pulse    <= 1'b0;
      end
      else
      begin
         counter_run_bit <= next_run;
         run_prev        <= counter_run_bit;
         count           <= next_count;
         if (cap_edge)
            compare_a_value <= count;
         else if (compare_a_write)
            compare_a_value <= compare_a_wdata;
         timer_output    <= next_out;
         flag_a_pulse    <= next_flag_a;
         flag_p_pulse    <= next_flag_p;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_single_end_flag: assert property (@(posedge clk) disable iff (rst)
      single_end |=> flag_a_pulse && !counter_run_bit)
      else $error("pulse end without flag or run clear");
   a_single_hold: assert property (@(posedge clk) disable iff (rst)
      single_end && !run_set && !trig_rise |=> count == $past(count))
      else $error("counter moved at pulse end");
   a_trig_sets_run: assert property (@(posedge clk) disable iff (rst)
      is_single && trig_rise |=> counter_run_bit)
      else $error("trigger did not set run");
   a_restart_zero: assert property (@(posedge clk) disable iff (rst)
      run_rise |=> count == 16'h0000)
      else $error("counter not zeroed on start");
   a_capture_copy: assert property (@(posedge clk) disable iff (rst)
      cap_edge |=> compare_a_value == $past(count) && flag_a_pulse)
      else $error("capture did not copy counter");
   a_capture_none: assert property (@(posedge clk) disable iff (rst)
      is_capt && pin_action_select == 2'h3 |-> !cap_edge)
      else $error("capture with code 11");
   a_capture_wrap: assert property (@(posedge clk) disable iff (rst)
      is_capt && counter_run_bit && !run_rise && match_p |=> count == 16'h0000 && flag_p_pulse)
      else $error("capture P match did not wrap");
   a_capture_pin: assert property (@(posedge clk) disable iff (rst)
      is_capt ##1 is_capt |-> !timer_output)
      else $error("output driven in capture");
   a_pwm_clear: assert property (@(posedge clk) disable iff (rst)
      is_pwm && counter_run_bit && !run_rise && pwm_clear |=> count == 16'h0000)
      else $error("pwm period clear missed");
   a_pwm_full: assert property (@(posedge clk) disable iff (rst)
      is_pwm && pin_action_select == 2'h2 && duty_full |=>
      timer_output == ($past(output_initial_level) ^ $past(output_invert)))
      else $error("full duty not held");

   a_swap_period: assert property (@(posedge clk) disable iff (rst)
      is_pwm && duty_period_swap_select && counter_run_bit && !run_rise &&
      ({1'b0, count} == a_span - 17'h00001) |=> count == 16'h0000)
      else $error("swap period did not end at compare A");

   a_p_period: assert property (@(posedge clk) disable iff (rst)
      is_pwm && !duty_period_swap_select && counter_run_bit && !run_rise &&
      ({1'b0, count} == p_span - 17'h00001) |=> count == 16'h0000)
      else $error("period did not end at compare P");

   a_forced_count: assert property (@(posedge clk) disable iff (rst)
      is_pwm && pin_action_select == 2'h0 && counter_run_bit && !run_rise && !pwm_clear
      |=> count == $past(count) + 16'h0001)
      else $error("pwm counter stopped with pin forced");

   a_forced_low: assert property (@(posedge clk) disable iff (rst)
      is_pwm && pin_action_select == 2'h0 |=> !timer_output)
      else $error("forced low pin not low");

   a_forced_high: assert property (@(posedge clk) disable iff (rst)
      is_pwm && pin_action_select == 2'h1 |=> timer_output)
      else $error("forced high pin not high");

   a_pulse_lead: assert property (@(posedge clk) disable iff (rst)
      is_single && next_run && !counter_run_bit
      |=> counter_run_bit && (timer_output != $past(output_invert)))
      else $error("pulse leading edge missing");

   a_pulse_trail: assert property (@(posedge clk) disable iff (rst)
      is_single && counter_run_bit && !next_run
      |=> !counter_run_bit && (timer_output == $past(output_invert)))
      else $error("pulse trailing edge missing");

   a_soft_end: assert property (@(posedge clk) disable iff (rst)
      is_single && run_clear && !run_set && !trig_rise |=> !counter_run_bit)
      else $error("software clear did not end pulse");

   a_single_no_p: assert property (@(posedge clk) disable iff (rst)
      is_single |=> !flag_p_pulse)
      else $error("compare P used in single pulse");

   a_set_wins: assert property (@(posedge clk) disable iff (rst)
      run_set |=> counter_run_bit)
      else $error("run set lost");

   a_capt_count: assert property (@(posedge clk) disable iff (rst)
      is_capt && counter_run_bit && !run_rise && !match_p |=> count == $past(count) + 16'h0001)
      else $error("capture counter not free running");

   a_capt_stop: assert property (@(posedge clk) disable iff (rst)
      is_capt && !counter_run_bit |=> count == $past(count))
      else $error("capture counter ran while stopped");

   a_capt_full: assert property (@(posedge clk) disable iff (rst)
      is_capt && counter_run_bit && !run_rise && compare_p_value == 8'h00 && count == 16'hffff
      |=> count == 16'h0000 && flag_p_pulse)
      else $error("full count wrap missed");

   a_capt_below: assert property (@(posedge clk) disable iff (rst)
      is_capt && compare_p_value == 8'h00 && count != 16'hffff |=> !flag_p_pulse)
      else $error("early wrap with P zero");

   a_capt_silent: assert property (@(posedge clk) disable iff (rst)
      is_capt && pin_action_select == 2'h3 |=> !flag_a_pulse)
      else $error("capture flag with code 11");

   a_pwm_active: assert property (@(posedge clk) disable iff (rst)
      is_pwm && pin_action_select == 2'h2 && ({1'b0, count} < duty)
      |=> timer_output == ($past(output_initial_level) ^ $past(output_invert)))
      else $error("pwm active level wrong");

   a_pwm_idle: assert property (@(posedge clk) disable iff (rst)
      is_pwm && pin_action_select == 2'h2 && !duty_full && ({1'b0, count} >= duty)
      |=> timer_output == !($past(output_initial_level) ^ $past(output_invert)))
      else $error("pwm idle level wrong");

   a_trig_once: assert property (@(posedge clk) disable iff (rst)
      trig_rise |=> !trig_rise)
      else $error("trigger edge seen twice");

   a_cap_once: assert property (@(posedge clk) disable iff (rst)
      cap_rise |=> !cap_rise)
      else $error("capture edge seen twice");

   a_rise_only: assert property (@(posedge clk) disable iff (rst)
      is_capt && pin_action_select == 2'h0 && cap_fall && !cap_rise |-> !cap_edge)
      else $error("falling edge captured in rise code");
endmodule : tpp_timer
`default_nettype wire

// [verif/tpp_pin_model.sv]
// Far-side model: sources for the trigger and capture pins.
// Assumes the pins are asynchronous to the timer clock.
`default_nettype none
module tpp_pin_model
(
   output logic trig,
   output logic cap
);
   timeunit 1ns;
   timeprecision 1ps;
   // -----------------------------------------------------------
   // Pin drivers
   // -----------------------------------------------------------
   // Odd delay keeps pin edges away from clock edges
   initial
   begin
      trig = 1'b0;
      cap  = 1'b0;
   end
   task automatic set_trig(input logic v);
   begin
      #2.3 trig = v;
   end
   endtask : set_trig
   task automatic set_cap(input logic v);
   begin
      #2.3 cap = v;
   end
   endtask : set_cap
endmodule : tpp_pin_model
`default_nettype wire

// [verif/tb_timer_pwm_pulse_capture.sv]
// Bench for the timer channel: single pulse, capture and PWM.
// Assumes a 200 MHz clock; control bits are plain ports.
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_timer_pwm_pulse_capture;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, msh = 0, msl = 0, oil = 0, inv = 0, ccs = 0, swp = 0;
   logic rs = 0, rc = 0, aw = 0, trig, cap, run, out, fa, fp;
   logic [1:0] pas = 2'h0;
   logic [15:0] aw_d = 16'h0000, a_v, cnt;
   logic [7:0] p_v = 8'h00;
   int errors = 0, checks_done = 0, n, h;
   tpp_pin_model tpp_pin_model_i (.trig(trig), .cap(cap));
   tpp_timer tpp_timer_i (.clk(clk), .rst(rst), .mode_select_hi(msh), .mode_select_lo(msl),
      .pin_action_select(pas), .output_initial_level(oil), .output_invert(inv),
      .clear_source_select(ccs), .duty_period_swap_select(swp), .run_set(rs), .run_clear(rc),
      .compare_a_write(aw), .compare_a_wdata(aw_d), .compare_p_value(p_v),
      .external_trigger_pin(trig), .capture_input_pin(cap), .counter_run_bit(run),
      .compare_a_value(a_v), .count(cnt), .timer_output(out), .flag_a_pulse(fa), .flag_p_pulse(fp));
   always #2.5 clk = ~clk;
   // -----------------------------------------------------------
   // Access tasks
   // -----------------------------------------------------------
   task automatic tick(input int k);
   begin
      repeat (k) @(posedge clk);
      #1;
   end
   endtask : tick
   task automatic strobe(input int which);
   begin
      tick(1);
      rs = (which == 0);
      rc = (which == 1);
      aw = (which == 2);
      tick(1);
      rs = 0;
      rc = 0;
      aw = 0;
   end
   endtask : strobe
   task automatic wait_fa(input int lim);
   begin
      n = 0;
      while (fa !== 1'b1 && n < lim) begin tick(1); n++; end
   end
   endtask : wait_fa
   task automatic end_of_test;
   begin
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   end
   endtask : end_of_test
   initial
   begin
      #200000 errors++;
      end_of_test();
   end
   // -----------------------------------------------------------
   // Tests
   // -----------------------------------------------------------
   initial
   begin
      int fl [4] = '{1, 1, 2, 0};
      tick(6);
      rst = 0;
      msh = 1; pas = 2'h3; swp = 1; ccs = 1; p_v = 8'h01; aw_d = 16'h0008;
      strobe(2);
      strobe(0);
      `CHK("run", 1'b1, run)
      `CHK("lead", 1'b1, out)
      wait_fa(40);
      tick(1);
      `CHK("run end", 1'b0, run)
      `CHK("trail", 1'b0, out)
      tick(3);
      `CHK("held", 16'h0008, cnt)
      tpp_pin_model_i.set_trig(1);
      tick(5);
      `CHK("trig run", 1'b1, run)
      `CHK("restart", 1'b1, cnt < 16'h0005)
      wait_fa(40);
      `CHK("flag a", 1'b1, fa)
      strobe(0);
      tick(1);
      strobe(1);
      tick(1);
      `CHK("sw end", 1'b0, out)
      // Capture: one edge per single-edge code, both-edge code sees two, code 11 sees none
      msh = 0; msl = 1; pas = 2'h0; p_v = 8'h00; oil = 1; inv = 1;
      strobe(0);
      tick(20);
      tpp_pin_model_i.set_cap(1);
      wait_fa(8);
      `CHK("cap val", 1'b1, a_v >= 16'd18 && a_v <= 16'd27)
      `CHK("cap out", 1'b0, out)
      tpp_pin_model_i.set_cap(0);
      tick(6);
      for (int c = 0; c < 4; c++)
      begin
         pas = c[1:0];
         h = 0;
         tick(2);
         tpp_pin_model_i.set_cap(1);
         repeat (6) begin tick(1); h += fa; end
         tpp_pin_model_i.set_cap(0);
         repeat (6) begin tick(1); h += fa; end
         `CHK("edges", fl[c], h)
      end
      `CHK("free run", 1'b1, cnt > 16'd60)
      p_v = 8'h01;
      h = 0;
      repeat (300) begin tick(1); h += fp; end
      `CHK("p wrap", 1'b1, h > 0 && cnt < 16'h0100)
      // PWM: period P*256, duty A; then duty above period
      strobe(1);
      msh = 1; msl = 0; pas = 2'h2; swp = 0; inv = 0; aw_d = 16'h0040;
      strobe(2);
      strobe(0);
      tick(300);
      h = 0;
      repeat (256) begin tick(1); h += out; end
      `CHK("duty", 1'b1, h == 64)
      // Restart so the shorter period is not overrun into a full wrap
      strobe(1);
      swp = 1; aw_d = 16'h0064;
      strobe(2);
      strobe(0);
      tick(300);
      h = 0;
      repeat (256) begin tick(1); h += out; end
      `CHK("full", 1'b1, h == 256)
      pas = 2'h1;
      wait_fa(200);
      `CHK("forced", 1'b1, fa === 1'b1 && out === 1'b1)
      end_of_test();
   end
endmodule : tb_timer_pwm_pulse_capture
`default_nettype wire
